// ---- rtl/led_regs_pkg.sv ----
// Shared constants and types for the LED driver configuration and status register bank
package led_regs_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] GREEN_CURRENT_OFS   = 8'h06;
  localparam logic [7:0] BLUE_CURRENT_OFS    = 8'h07;
  localparam logic [7:0] DEVICE_CONFIG_OFS   = 8'h08;
  localparam logic [7:0] RED_PC_OFS          = 8'h09;
  localparam logic [7:0] GREEN_PC_OFS        = 8'h0a;
  localparam logic [7:0] BLUE_PC_OFS         = 8'h0b;
  localparam logic [7:0] STATUS_FLAGS_OFS    = 8'h0c;
  localparam logic [7:0] SOFT_RESET_OFS      = 8'h0d;
  localparam logic [7:0] GENERAL_OUTPUT_OFS  = 8'h0e;

  // ==========================================================================
  // Reset values and command codes
  localparam logic [7:0] CURRENT_RESET       = 8'haf;
  localparam logic [3:0] PC_RESET            = 4'h0;
  localparam logic [7:0] SOFT_RESET_CODE     = 8'hff;
  localparam logic [1:0] RUN_STATE_HOLD      = 2'h0;

  // ==========================================================================
  // Clock source select codes
  localparam logic [1:0] CLK_SRC_EXTERNAL    = 2'h0;
  localparam logic [1:0] CLK_SRC_AUTO        = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CORE_CLOCK_HZ      = 125_000_000;
  localparam int SLOW_CLOCK_HZ      = 32_768;
  localparam int PWM_SLOW_HZ        = 256;
  localparam int PWM_FAST_HZ        = 558;
  localparam int OSC_TICK_CYCLES    = CORE_CLOCK_HZ / SLOW_CLOCK_HZ;
  localparam int PWM_SLOW_TICKS     = SLOW_CLOCK_HZ / PWM_SLOW_HZ;
  localparam int PWM_FAST_CYCLES    = CORE_CLOCK_HZ / PWM_FAST_HZ;
  localparam int EXT_LOSS_TICKS     = 4;

  // ==========================================================================
  // Configuration register fields, bit 6 down to bit 0
  typedef struct packed {
    logic       pwm_fast_clock_select;
    logic       power_save_enable;
    logic [1:0] pump_gain_select;
    logic       red_supply_select;
    logic [1:0] clock_source;
  } config_t;

  // ==========================================================================
  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]       green_current;
    logic [7:0]       blue_current;
    config_t          cfg;
    logic [2:0][3:0]  pc;
    logic [2:0]       pc_pend;
    logic [2:0][3:0]  pc_pend_val;
    logic [2:0]       pc_load;
    logic [2:0]       irq_flags;
    logic [2:0]       general_output_control;
    logic             ext_sync1;
    logic             ext_sync2;
    logic             ext_prev;
    logic [11:0]      osc_cnt;
    logic [2:0]       loss_cnt;
    logic             slow_tick;
    logic [6:0]       pwm_div;
    logic [17:0]      pwm_fast_cnt;
    logic             pwm_tick;
    logic [7:0]       rdata;
    logic             rvalid;
  } state_t;

endpackage

// ---- rtl/led_config_status_regs.sv ----
// Configuration, program counter, status and general output registers of the LED driver
`timescale 1ns/100ps
`default_nettype none
module led_config_status_regs
  import led_regs_pkg::*;
#(
  parameter int P_PWM_FAST_CYCLES = PWM_FAST_CYCLES
) (
  // Clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_resetn,
  // Register port from the serial front end
  input  wire logic [7:0]      i_reg_addr,
  input  wire logic [7:0]      i_reg_wdata,
  input  wire logic            i_reg_wr,
  input  wire logic            i_reg_rd,
  output logic                 o_reg_ack,
  output logic [7:0]           o_reg_rdata,
  output logic                 o_reg_rvalid,
  // Instruction engines
  input  wire logic [2:0][1:0] i_program_run_state,
  input  wire logic [2:0]      i_engine_pc_wr,
  input  wire logic [2:0][3:0] i_engine_pc_val,
  input  wire logic [2:0]      i_chan_irq,
  output logic [2:0][3:0]      o_program_counter,
  output logic [2:0]           o_pc_load,
  // Analogue and clock controls
  output logic [7:0]           o_green_current,
  output logic [7:0]           o_blue_current,
  output config_t              o_config,
  output logic                 o_slow_tick,
  output logic                 o_pwm_tick,
  output logic                 o_external_clock_in_use,
  // Pins
  input  wire logic            i_slow_external_clock,
  output logic                 o_irq_n,
  output logic                 o_general_output_pin
);

  // ==========================================================================
  // State
  localparam state_t STATE_RESET = '{
    green_current: CURRENT_RESET,
    blue_current:  CURRENT_RESET,
    pc:            {3{PC_RESET}},
    pc_pend_val:   {3{PC_RESET}},
    loss_cnt:      3'(EXT_LOSS_TICKS), // Pin counts as dead until its first edge
    default:       '0
  };

  state_t state_reg;     // Registered state
  state_t state_next;    // Next state
  logic   host_wr_reset; // Host wrote the soft reset code
  logic   use_ext;       // Slow clock taken from the pin
  logic   ext_edge;      // Rising edge of the synchronised pin
  logic   ext_ok;        // Pin clock seen recently

  // Soft reset write is matched combinationally so the acknowledge can be withheld
  assign host_wr_reset = i_reg_wr && (i_reg_addr == SOFT_RESET_OFS) && (i_reg_wdata == SOFT_RESET_CODE);
  assign ext_edge      = state_reg.ext_sync2 && !state_reg.ext_prev;
  assign ext_ok        = (state_reg.loss_cnt < 3'(EXT_LOSS_TICKS));

  // Source of the slow clock: pin, oscillator, or pin while it keeps toggling
  always_comb begin
    case (state_reg.cfg.clock_source)
      CLK_SRC_EXTERNAL: use_ext = 1'b1;
      CLK_SRC_AUTO:     use_ext = ext_ok;
      default:          use_ext = 1'b0;    // Both remaining codes mean internal
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_next           = state_reg;
    state_next.pc_load   = '0;
    state_next.rvalid    = 1'b0;

    // Two-stage synchroniser for the slow clock pin; only stage two is used
    state_next.ext_sync1 = i_slow_external_clock;
    state_next.ext_sync2 = state_reg.ext_sync1;
    state_next.ext_prev  = state_reg.ext_sync2;

    // Internal oscillator stand-in: divider on the core clock
    if (state_reg.osc_cnt == 12'(OSC_TICK_CYCLES - 1)) begin
      state_next.osc_cnt = '0;
      // Loss counter saturates, so a dead pin clock stays detected
      if (!ext_ok) begin
        state_next.loss_cnt = state_reg.loss_cnt;
      end else begin
        state_next.loss_cnt = state_reg.loss_cnt + 3'h1;
      end
    end else begin
      state_next.osc_cnt = state_reg.osc_cnt + 12'h1;
    end
    if (ext_edge) begin
      state_next.loss_cnt = '0;
    end

    // Slow tick paces host counter updates and the slow PWM clock
    state_next.slow_tick = use_ext ? ext_edge : (state_reg.osc_cnt == 12'(OSC_TICK_CYCLES - 1));

    // PWM clock: slow clock divided, or fast from its own core clock divider
    state_next.pwm_tick = 1'b0;
    if (state_reg.cfg.pwm_fast_clock_select) begin
      state_next.pwm_div = '0;
      if (state_reg.pwm_fast_cnt == 18'(P_PWM_FAST_CYCLES - 1)) begin
        state_next.pwm_fast_cnt = '0;
        state_next.pwm_tick     = 1'b1;
      end else begin
        state_next.pwm_fast_cnt = state_reg.pwm_fast_cnt + 18'h1;
      end
    end else begin
      state_next.pwm_fast_cnt = '0;
      if (state_reg.slow_tick) begin
        state_next.pwm_div = state_reg.pwm_div + 7'h1;
        if (state_reg.pwm_div == 7'(PWM_SLOW_TICKS - 1)) begin
          state_next.pwm_tick = 1'b1;
        end
      end
    end

    // Engine updates of the counters; an engine write moves its counter whatever the run state
    for (int ch = 0; ch < 3; ch++) begin
      if (i_engine_pc_wr[ch]) begin
        state_next.pc[ch] = i_engine_pc_val[ch];
      end
      // Host write lands on the next slow tick if still held, else is dropped; a later write before it replaces it
      if (state_reg.pc_pend[ch] && state_reg.slow_tick) begin
        state_next.pc_pend[ch] = 1'b0;
        if (i_program_run_state[ch] == RUN_STATE_HOLD) begin
          state_next.pc[ch]      = state_reg.pc_pend_val[ch];
          state_next.pc_load[ch] = 1'b1;
        end
      end
    end

    // Host register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        GREEN_CURRENT_OFS:  state_next.green_current = i_reg_wdata;
        BLUE_CURRENT_OFS:   state_next.blue_current  = i_reg_wdata;
        DEVICE_CONFIG_OFS:  state_next.cfg           = config_t'(i_reg_wdata[6:0]);
        RED_PC_OFS, GREEN_PC_OFS, BLUE_PC_OFS: begin
          // Writes outside hold are dropped
          for (int ch = 0; ch < 3; ch++) begin
            if ((i_reg_addr == RED_PC_OFS + 8'(2 - ch)) &&
                (i_program_run_state[ch] == RUN_STATE_HOLD)) begin
              state_next.pc_pend[ch]     = 1'b1;
              state_next.pc_pend_val[ch] = i_reg_wdata[3:0];
            end
          end
        end
        GENERAL_OUTPUT_OFS: state_next.general_output_control = i_reg_wdata[2:0];
        default: ;          // Status, reset and unmapped offsets store nothing
      endcase
    end

    // Host register reads, answered one cycle later
    if (i_reg_rd) begin
      state_next.rvalid = 1'b1;
      case (i_reg_addr)
        GREEN_CURRENT_OFS:  state_next.rdata = state_reg.green_current;
        BLUE_CURRENT_OFS:   state_next.rdata = state_reg.blue_current;
        DEVICE_CONFIG_OFS:  state_next.rdata = {1'b0, state_reg.cfg};
        // Counters read as zero while the engine is not held
        RED_PC_OFS:   state_next.rdata = (i_program_run_state[2] == RUN_STATE_HOLD) ? {4'h0, state_reg.pc[2]} : 8'h00;
        GREEN_PC_OFS: state_next.rdata = (i_program_run_state[1] == RUN_STATE_HOLD) ? {4'h0, state_reg.pc[1]} : 8'h00;
        BLUE_PC_OFS:  state_next.rdata = (i_program_run_state[0] == RUN_STATE_HOLD) ? {4'h0, state_reg.pc[0]} : 8'h00;
        STATUS_FLAGS_OFS: begin
          state_next.rdata     = {4'h0, use_ext, state_reg.irq_flags};
          state_next.irq_flags = '0;
        end
        GENERAL_OUTPUT_OFS: state_next.rdata = {5'h00, state_reg.general_output_control};
        default:            state_next.rdata = 8'h00;
      endcase
    end

    // New channel events win over a clearing read in the same cycle
    state_next.irq_flags = state_next.irq_flags | i_chan_irq;

    // Soft reset returns every register to its reset value, timing logic keeps running
    if (host_wr_reset) begin
      state_next.green_current = CURRENT_RESET;
      state_next.blue_current  = CURRENT_RESET;
      state_next.cfg           = '0;
      state_next.pc            = {3{PC_RESET}};
      state_next.pc_pend       = '0;
      state_next.irq_flags     = '0;
      state_next.general_output_control           = '0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_reg_ack               = i_reg_wr && !host_wr_reset;
  assign o_reg_rdata             = state_reg.rdata;
  assign o_reg_rvalid            = state_reg.rvalid;
  assign o_program_counter       = state_reg.pc;
  assign o_pc_load               = state_reg.pc_load;
  assign o_green_current         = state_reg.green_current;
  assign o_blue_current          = state_reg.blue_current;
  assign o_config                = state_reg.cfg;
  assign o_slow_tick             = state_reg.slow_tick;
  assign o_pwm_tick              = state_reg.pwm_tick;
  assign o_external_clock_in_use = use_ext;
  assign o_general_output_pin    = state_reg.general_output_control[1];
  // Interrupt pin: flag summary, or plain output when repurposed
  assign o_irq_n = state_reg.general_output_control[2] ? state_reg.general_output_control[0] : !(|state_reg.irq_flags);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence seq_status_read;
    i_reg_rd && (i_reg_addr == STATUS_FLAGS_OFS) && !host_wr_reset;
  endsequence

  sequence seq_reset_write;
    host_wr_reset;
  endsequence

  AST_STATUS_READ_CLEARS: assert property (seq_status_read ##0 (i_chan_irq == 3'h0) |=>
    (state_reg.irq_flags == 3'h0) && o_reg_rvalid)
    else $error("status read did not clear flags");

  AST_EVENT_WINS_CLEAR: assert property (seq_status_read ##0 i_chan_irq[2] |=>
    state_reg.irq_flags[2] && $past(state_reg.irq_flags[2], 1) == o_reg_rdata[2])
    else $error("event lost against status read");

  AST_SOFT_RESET_VALUES: assert property (seq_reset_write |=>
    (o_green_current == CURRENT_RESET) && (o_blue_current == CURRENT_RESET) && (o_config == '0))
    else $error("soft reset did not restore registers");

  AST_SOFT_RESET_NO_ACK: assert property (seq_reset_write |-> !o_reg_ack)
    else $error("soft reset write was acknowledged");

  AST_PC_HELD_OUTSIDE_HOLD: assert property (
    (i_program_run_state[2] != RUN_STATE_HOLD) && !i_engine_pc_wr[2] && !host_wr_reset
      |=> $stable(o_program_counter[2]))
    else $error("program counter moved outside hold");

  AST_PC_WAITS_TICK: assert property (
    state_reg.pc_pend[2] && !state_reg.slow_tick && !host_wr_reset && !(i_reg_wr && i_reg_addr == RED_PC_OFS)
      |=> state_reg.pc_pend[2] && !o_pc_load[2])
    else $error("counter write bypassed slow tick");

  AST_IRQ_PIN_ASSERTED: assert property (
    (state_reg.irq_flags != 3'h0) && !state_reg.general_output_control[2] |-> !o_irq_n)
    else $error("interrupt pin not asserted");

  AST_IRQ_PIN_AS_OUTPUT: assert property (
    i_reg_wr && (i_reg_addr == GENERAL_OUTPUT_OFS) && i_reg_wdata[2] |=> o_irq_n == $past(i_reg_wdata[0], 1))
    else $error("repurposed interrupt pin wrong level");

  AST_STATUS_UPPER_ZERO: assert property (seq_status_read |=> o_reg_rdata[7:4] == 4'h0)
    else $error("status upper bits not zero");

  AST_PWM_FAST_PERIOD: assert property (
    o_pwm_tick && o_config.pwm_fast_clock_select |=> !o_pwm_tick [*8])
    else $error("fast PWM tick too frequent");

  // Register writes land one cycle after the strobe
  AST_CURRENT_WRITE: assert property (
    i_reg_wr && (i_reg_addr == GREEN_CURRENT_OFS) |=> o_green_current == $past(i_reg_wdata))
    else $error("green current write lost");

  AST_CONFIG_WRITE: assert property (
    i_reg_wr && (i_reg_addr == DEVICE_CONFIG_OFS) |=> o_config == config_t'($past(i_reg_wdata[6:0])))
    else $error("configuration write lost");

  AST_GPO_PIN: assert property (
    i_reg_wr && (i_reg_addr == GENERAL_OUTPUT_OFS) |=> o_general_output_pin == $past(i_reg_wdata[1]))
    else $error("general output pin wrong level");

  // Slow clock source follows the select code
  AST_CLOCK_EXTERNAL: assert property (
    (o_config.clock_source == CLK_SRC_EXTERNAL) |-> o_external_clock_in_use)
    else $error("forced pin clock not in use");

  AST_CLOCK_INTERNAL: assert property (o_config.clock_source[0] |-> !o_external_clock_in_use)
    else $error("internal clock code used the pin");

  AST_STATUS_EXT_BIT: assert property (
    seq_status_read |=> o_reg_rdata[3] == $past(o_external_clock_in_use))
    else $error("status clock bit wrong");

  // Refused and narrow reads
  AST_PC_REFUSED_READ: assert property (
    i_reg_rd && (i_reg_addr == RED_PC_OFS) && (i_program_run_state[2] != RUN_STATE_HOLD) |=> o_reg_rdata == 8'h00)
    else $error("counter read outside hold");

  AST_PC_UPPER_ZERO: assert property (
    i_reg_rd && (i_reg_addr >= RED_PC_OFS) && (i_reg_addr <= BLUE_PC_OFS) |=> o_reg_rdata[7:4] == 4'h0)
    else $error("counter upper bits not zero");

  AST_GPO_UPPER_ZERO: assert property (
    i_reg_rd && (i_reg_addr == GENERAL_OUTPUT_OFS) |=> o_reg_rdata[7:3] == 5'h00)
    else $error("output control upper bits not zero");

  // Host counter write: parked first, applied on a slow tick while held
  sequence seq_red_pc_apply;
    state_reg.pc_pend[2] && state_reg.slow_tick && (i_program_run_state[2] == RUN_STATE_HOLD) && !host_wr_reset;
  endsequence

  AST_PC_PENDING: assert property (
    i_reg_wr && (i_reg_addr == RED_PC_OFS) && (i_program_run_state[2] == RUN_STATE_HOLD) && !host_wr_reset
      |=> state_reg.pc_pend[2] && (state_reg.pc_pend_val[2] == $past(i_reg_wdata[3:0])))
    else $error("held counter write not parked");

  AST_PC_APPLY: assert property (
    seq_red_pc_apply |=> o_pc_load[2] && (o_program_counter[2] == $past(state_reg.pc_pend_val[2])))
    else $error("parked counter write not applied");

  // Soft reset and interrupt pin release
  AST_SOFT_RESET_CLEARS: assert property (
    seq_reset_write |=> (o_program_counter == '0) && o_irq_n && !o_general_output_pin)
    else $error("soft reset left counters or pins set");

  AST_IRQ_PIN_RELEASED: assert property (
    (state_reg.irq_flags == 3'h0) && !state_reg.general_output_control[2] |-> o_irq_n)
    else $error("interrupt pin low without flags");

endmodule
`default_nettype wire

// ---- tb/led_host_model.sv ----
// Host model that reaches the register bank through its register port
`timescale 1ns/100ps
`default_nettype none
module led_host_model
  import led_regs_pkg::*;
(
  // Clock
  input  wire logic       i_core_clk,
  // Register port towards the device
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  input  wire logic       i_reg_ack,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid
);
  // Just over 153 us of 8 ns cycles between counter writes
  localparam int PC_GAP = 19200;

  // ==========================================================================
  // Idle bus at time zero
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
  end

  // ==========================================================================
  // Write one byte; the ack is taken at the edge that takes the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
    @(posedge i_core_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    ack = i_reg_ack; // A missing ack is handed back, never waited
    o_reg_wr    <= 1'b0;
    // Released lines show the inverse so stale values never look valid
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
    // Counters follow the slow clock, so a long gap follows each counter write
    if (a >= RED_PC_OFS && a <= BLUE_PC_OFS) begin
      repeat (PC_GAP) @(posedge i_core_clk);
    end
  endtask

  // ==========================================================================
  // Read one byte; data is valid exactly one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_core_clk);
    // No valid pulse gives unknown data, so the compare cannot pass
    d = i_reg_rvalid ? i_reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ---- tb/led_config_status_regs_bench.sv ----
// Self-checking bench for the LED driver configuration and status registers
`timescale 1ns/100ps
`default_nettype none
module led_config_status_regs_bench;
  import led_regs_pkg::*;
  localparam int FAST_CYC   = 50;    // Shortened fast PWM divider
  localparam int TIME_LIMIT = 90000; // Two counter gaps plus margin
  logic            i_core_clk;
  logic            i_resetn;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, rdat, green_cur, blue_cur;
  logic            reg_wr, reg_rd, reg_ack, reg_rvalid, ack;
  logic [2:0][1:0] run_state;
  logic [2:0]      eng_pc_wr, chan_irq;
  logic [2:0][3:0] eng_pc_val, prog_cnt;
  config_t         cfg;
  logic            pwm_tick, slow_ext_clk, irq_n, gpo_pin, slow_tick, ext_used;
  logic [2:0]      pc_load;
  int              err_total, compares, cycles, ticks, loads;

  // ==========================================================================
  // Device and host
  led_config_status_regs #(.P_PWM_FAST_CYCLES(FAST_CYC)) led_config_status_regs_inst (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_ack(reg_ack),
    .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .i_program_run_state(run_state),
    .i_engine_pc_wr(eng_pc_wr), .i_engine_pc_val(eng_pc_val), .i_chan_irq(chan_irq),
    .o_program_counter(prog_cnt), .o_pc_load(pc_load), .o_green_current(green_cur),
    .o_blue_current(blue_cur), .o_config(cfg), .o_slow_tick(slow_tick), .o_pwm_tick(pwm_tick),
    .o_external_clock_in_use(ext_used), .i_slow_external_clock(slow_ext_clk), .o_irq_n(irq_n),
    .o_general_output_pin(gpo_pin));
  led_host_model led_host_model_inst (
    .i_core_clk(i_core_clk), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .i_reg_ack(reg_ack), .i_reg_rdata(reg_rdata),
    .i_reg_rvalid(reg_rvalid));

  // ==========================================================================
  // Clock and hang guard
  initial i_core_clk = 1'b0;
  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (pc_load[2] === 1'b1) loads = loads + 1;
    if (cycles == TIME_LIMIT) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: run timed out", $time);
      wrap_up();
    end
  end

  // ==========================================================================
  // Shared compare and access helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    led_host_model_inst.rd(a, rdat);
    chk(rdat, e, "read data");
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    led_host_model_inst.wr(a, d, ack);
  endtask
  // Let the taking edge's register updates land before looking
  task automatic settle();
    @(negedge i_core_clk);
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    i_resetn = 1'b0;
    run_state = '0; // All channels in hold unless a test says otherwise
    eng_pc_wr = '0;
    eng_pc_val = '0;
    chan_irq = '0;
    slow_ext_clk = 1'b0;
    err_total = 0;
    compares = 0;
    cycles = 0;
    loads = 0;
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    // Reset values
    r(GREEN_CURRENT_OFS, CURRENT_RESET);
    r(BLUE_CURRENT_OFS, CURRENT_RESET);
    r(DEVICE_CONFIG_OFS, 8'h00);
    for (int i = 0; i < 3; i++) r(RED_PC_OFS + 8'(i), 8'h00);
    r(STATUS_FLAGS_OFS, 8'h08);
    r(GENERAL_OUTPUT_OFS, 8'h00);
    chk(8'(irq_n), 8'h01, "idle irq");
    $display("test reset_values done");
    // Current codes at both ends of the range
    w(GREEN_CURRENT_OFS, 8'h00);
    w(BLUE_CURRENT_OFS, 8'hff);
    settle();
    chk(green_cur, 8'h00, "green current");
    chk(blue_cur, 8'hff, "blue current");
    r(BLUE_CURRENT_OFS, 8'hff);
    $display("test currents done");
    // Every pump gain and clock source code
    for (int i = 0; i < 4; i++) begin
      w(DEVICE_CONFIG_OFS, {3'b001, 2'(i), 1'b1, 2'(i)});
      settle();
      chk(8'(cfg.pump_gain_select), 8'(i), "pump gain");
      chk(8'(cfg.clock_source), 8'(i), "clock source");
      chk(8'(cfg.power_save_enable), 8'h01, "power save");
      chk(8'(cfg.red_supply_select), 8'h01, "red supply");
      r(STATUS_FLAGS_OFS, {4'h0, i == 0, 3'b000});
    end
    // One pin edge: one slow tick when forced, then auto mode takes the pin
    w(DEVICE_CONFIG_OFS, 8'h00);
    slow_ext_clk <= 1'b1;
    ticks = 0;
    repeat (8) begin
      @(posedge i_core_clk);
      if (slow_tick === 1'b1) ticks = ticks + 1;
    end
    chk(8'(ticks), 8'h01, "pin slow ticks");
    w(DEVICE_CONFIG_OFS, 8'h02);
    r(STATUS_FLAGS_OFS, 8'h08);
    chk(8'(ext_used), 8'h01, "auto picks pin");
    // Fast PWM clock from the internal divider, internal slow clock
    w(DEVICE_CONFIG_OFS, 8'h41);
    ticks = 0;
    repeat (10 * FAST_CYC) begin
      @(posedge i_core_clk);
      if (pwm_tick === 1'b1) ticks = ticks + 1;
    end
    chk(8'(ticks >= 9 && ticks <= 11), 8'h01, "fast pwm ticks");
    $display("test config done");
    // Counter write in hold, then refused access outside hold
    w(RED_PC_OFS, 8'hf5);
    settle();
    chk(8'(prog_cnt[2]), 8'h05, "red counter");
    r(RED_PC_OFS, 8'h05);
    @(posedge i_core_clk);
    run_state[2] <= 2'b10;
    r(RED_PC_OFS, 8'h00);
    w(RED_PC_OFS, 8'h0a);
    settle();
    chk(8'(prog_cnt[2]), 8'h05, "dropped write");
    @(posedge i_core_clk);
    eng_pc_val[2] <= 4'h3;
    eng_pc_wr[2] <= 1'b1;
    @(posedge i_core_clk);
    eng_pc_wr[2] <= 1'b0;
    settle();
    chk(8'(prog_cnt[2]), 8'h03, "engine counter");
    chk(8'(loads), 8'h01, "host loads");
    @(posedge i_core_clk);
    run_state[2] <= 2'b00;
    r(RED_PC_OFS, 8'h03);
    $display("test counters done");
    // Channel flags, clear on read, pin taken over as output
    @(posedge i_core_clk);
    chan_irq <= 3'b101;
    @(posedge i_core_clk);
    chan_irq <= 3'b000;
    settle();
    chk(8'(irq_n), 8'h00, "irq asserted");
    r(STATUS_FLAGS_OFS, 8'h05);
    settle();
    chk(8'(irq_n), 8'h01, "irq released");
    r(STATUS_FLAGS_OFS, 8'h00);
    // A flag whose event stays high through the clearing read survives it
    @(posedge i_core_clk);
    chan_irq <= 3'b100;
    r(STATUS_FLAGS_OFS, 8'h04);
    chan_irq <= 3'b000;
    r(STATUS_FLAGS_OFS, 8'h04);
    r(STATUS_FLAGS_OFS, 8'h00);
    @(posedge i_core_clk);
    chan_irq <= 3'b010;
    @(posedge i_core_clk);
    chan_irq <= 3'b000;
    w(GENERAL_OUTPUT_OFS, 8'h05);
    settle();
    chk(8'(irq_n), 8'h01, "pin as output high");
    chk(8'(gpo_pin), 8'h00, "gpo low");
    w(GENERAL_OUTPUT_OFS, 8'hfe);
    settle();
    chk(8'(irq_n), 8'h00, "pin as output low");
    chk(8'(gpo_pin), 8'h01, "gpo high");
    r(GENERAL_OUTPUT_OFS, 8'h06);
    w(GENERAL_OUTPUT_OFS, 8'h00);
    settle();
    chk(8'(irq_n), 8'h00, "pending flag");
    r(STATUS_FLAGS_OFS, 8'h02);
    settle();
    chk(8'(irq_n), 8'h01, "flag cleared");
    $display("test interrupts done");
    // Soft reset command, other codes and unmapped places
    w(BLUE_CURRENT_OFS, 8'h12);
    w(SOFT_RESET_OFS, 8'h12);
    chk(8'(ack), 8'h01, "plain ack");
    r(BLUE_CURRENT_OFS, 8'h12);
    r(SOFT_RESET_OFS, 8'h00);
    r(8'h0f, 8'h00);
    w(SOFT_RESET_OFS, SOFT_RESET_CODE);
    chk(8'(ack), 8'h00, "no ack");
    r(BLUE_CURRENT_OFS, CURRENT_RESET);
    r(DEVICE_CONFIG_OFS, 8'h00);
    w(STATUS_FLAGS_OFS, 8'h07);
    r(STATUS_FLAGS_OFS, 8'h08);
    $display("test soft_reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
